// >>> common/tmm_defines.svh
// constants for the general purpose down-counting timer block
// assumes inclusion by bare name from the package and the design file
`ifndef TMM_DEFINES_SVH
`define TMM_DEFINES_SVH

`define TMM_NUM_TIMERS   4
`define TMM_CNT_W        16
`define TMM_BYTE_W       8
`define TMM_SEL_W        2

`define TMM_SEL_13M56    2'h0
`define TMM_SEL_212K     2'h1
`define TMM_SEL_WAKEUP   2'h2
`define TMM_SEL_NONE     2'h3

`define TMM_CNT_RST      16'h0000
`define TMM_CNT_ZERO     16'h0000
`define TMM_CNT_ONE      16'h0001

`endif

// >>> common/tmm_pkg.sv
// types shared by the timer block and its surroundings
// assumes tmm_defines.svh is on the include path
`include "tmm_defines.svh"

package tmm_pkg;

  typedef enum logic [1:0] {
    TMM_CLK_13M56  = 2'b00,
    TMM_CLK_212K   = 2'b01,
    TMM_CLK_WAKEUP = 2'b10,
    TMM_CLK_NONE   = 2'b11
  } tmm_clk_sel_t;

  typedef enum logic {
    TMM_ST_IDLE  = 1'b0,
    TMM_ST_COUNT = 1'b1
  } tmm_state_t;

  // per timer configuration, held by the host side
  typedef struct packed {
    logic [`TMM_BYTE_W-1:0] reload_value_high;
    logic [`TMM_BYTE_W-1:0] reload_value_low;
    tmm_clk_sel_t           clk_sel;
    logic                   auto_reload_on_underflow;
    logic                   irq_enable;
  } tmm_cfg_t;

  // per timer status shown to the host
  typedef struct packed {
    logic [`TMM_CNT_W-1:0] counter_value;
    logic                  running;
    logic                  irq_flag;
  } tmm_stat_t;

endpackage : tmm_pkg

// >>> rtl/tmm_timer.sv
// four down-counting timers: stop watch, one-shot and periodic trigger
// assumes ticks, stop events and host strobes are one-cycle pulses on sys_clk
// limitation: the protocol start bit is not modelled, starts come from writes only
`timescale 1ns/1ps
`include "tmm_defines.svh"

module tmm_timer (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire tmm_pkg::tmm_cfg_t            cfg        [`TMM_NUM_TIMERS],
  input  wire logic                         tick_13m56,
  input  wire logic                         tick_212k,
  input  wire logic                         wakeup_underflow,
  input  wire logic [`TMM_NUM_TIMERS-1:0]   stop_event,
  input  wire logic                         ctrl_wr,
  input  wire logic [`TMM_NUM_TIMERS-1:0]   ctrl_running,
  input  wire logic [`TMM_NUM_TIMERS-1:0]   immediate_start_stop,
  input  wire logic [`TMM_NUM_TIMERS-1:0]   irq_clear,
  input  wire logic [`TMM_NUM_TIMERS-1:0]   irq_set,
  output tmm_pkg::tmm_stat_t                stat       [`TMM_NUM_TIMERS],
  output logic                              irq
);

  tmm_pkg::tmm_state_t        state_r   [`TMM_NUM_TIMERS];
  tmm_pkg::tmm_state_t        state_nxt [`TMM_NUM_TIMERS];
  logic [`TMM_CNT_W-1:0]      cnt_r     [`TMM_NUM_TIMERS];
  logic [`TMM_CNT_W-1:0]      cnt_nxt   [`TMM_NUM_TIMERS];
  logic [`TMM_NUM_TIMERS-1:0] flag_r;
  logic [`TMM_NUM_TIMERS-1:0] flag_nxt;
  logic                       irq_r;
  logic                       irq_nxt;
  logic [`TMM_NUM_TIMERS-1:0] tick_vec;
  logic [`TMM_NUM_TIMERS-1:0] start_hit;
  logic [`TMM_NUM_TIMERS-1:0] stop_hit;
  logic [`TMM_NUM_TIMERS-1:0] restart_hit;
  logic [`TMM_NUM_TIMERS-1:0] uflow_vec;

  function automatic logic sel_tick(input tmm_pkg::tmm_clk_sel_t sel,
                                    input logic t13, input logic t212,
                                    input logic twk);
    case (sel)
      tmm_pkg::TMM_CLK_13M56:  sel_tick = t13;
      tmm_pkg::TMM_CLK_212K:   sel_tick = t212;
      tmm_pkg::TMM_CLK_WAKEUP: sel_tick = twk;
      default:                 sel_tick = 1'b0;
    endcase
  endfunction : sel_tick

  // reload assembled from high and low bytes
  function automatic logic [`TMM_CNT_W-1:0] reload_of(input tmm_pkg::tmm_cfg_t c);
    reload_of = {c.reload_value_high, c.reload_value_low};
  endfunction : reload_of

  // a control write reaches timer i only through its immediate bit
  function automatic logic ctrl_hit(input logic wr, input logic imm);
    ctrl_hit = wr && imm;
  endfunction : ctrl_hit

  // per timer tick and control decode; the running bit picks start or stop
  always_comb begin
    tick_vec    = '0;
    start_hit   = '0;
    stop_hit    = '0;
    restart_hit = '0;
    for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
      tick_vec[i]    = sel_tick(cfg[i].clk_sel, tick_13m56, tick_212k, wakeup_underflow);
      start_hit[i]   = ctrl_hit(ctrl_wr, immediate_start_stop[i]) && ctrl_running[i];
      stop_hit[i]    = ctrl_hit(ctrl_wr, immediate_start_stop[i]) && !ctrl_running[i];
      restart_hit[i] = ctrl_hit(ctrl_wr, immediate_start_stop[i]);
    end
  end

  // priority while counting: stop write, stop event, restart write, tick
  always_comb begin
    logic uflow;
    uflow     = 1'b0;
    uflow_vec = '0;
    for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
      state_nxt[i] = state_r[i];
      cnt_nxt[i]   = cnt_r[i];
      uflow        = 1'b0;
      case (state_r[i])
        tmm_pkg::TMM_ST_IDLE: begin
          if (start_hit[i]) begin
            cnt_nxt[i]   = reload_of(cfg[i]);
            state_nxt[i] = tmm_pkg::TMM_ST_COUNT;
          end
        end
        tmm_pkg::TMM_ST_COUNT: begin
          if (stop_hit[i]) begin
            state_nxt[i] = tmm_pkg::TMM_ST_IDLE;
          end else if (stop_event[i]) begin
            state_nxt[i] = tmm_pkg::TMM_ST_IDLE;
          end else if (restart_hit[i]) begin
            // a restart while counting reloads
            cnt_nxt[i] = reload_of(cfg[i]);
          end else if (tick_vec[i]) begin
            if (cnt_r[i] == `TMM_CNT_ZERO) begin
              uflow = 1'b1;
              if (cfg[i].auto_reload_on_underflow) begin
                cnt_nxt[i] = reload_of(cfg[i]);
              end else begin
                state_nxt[i] = tmm_pkg::TMM_ST_IDLE;
              end
            end else begin
              cnt_nxt[i] = cnt_r[i] - `TMM_CNT_ONE;
            end
          end
        end
        default: begin
          state_nxt[i] = tmm_pkg::TMM_ST_IDLE;
        end
      endcase
      uflow_vec[i] = uflow;
    end
  end

  // sticky flag, set beats clear
  // the host may set the flag too, which lets software test the pin path
  always_comb begin
    flag_nxt = flag_r;
    for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
      if (uflow_vec[i] || irq_set[i]) begin
        flag_nxt[i] = 1'b1;
      end else if (irq_clear[i]) begin
        flag_nxt[i] = 1'b0;
      end
    end
  end

  // pin gated by enable
  // looks at the next flag so that pin and flag change on the same edge
  always_comb begin
    irq_nxt = 1'b0;
    for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
      if (flag_nxt[i] && cfg[i].irq_enable) begin
        irq_nxt = 1'b1;
      end
    end
  end

  // no clock enable: ticks act as qualifiers, keeping a single clock tree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
        state_r[i] <= tmm_pkg::TMM_ST_IDLE;
      end
    end else begin
      for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
        state_r[i] <= state_nxt[i];
      end
    end
  end

  // counters come up at zero, the reload lands on a start, a restart write or an auto-reload underflow
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
        cnt_r[i] <= `TMM_CNT_RST;
      end
    end else begin
      for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // registered pin, free of decode glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // status straight from registers, so a host read never sees a glitch

  always_comb begin
    for (int i = 0; i < `TMM_NUM_TIMERS; i++) begin
      stat[i].counter_value = cnt_r[i];
      stat[i].running       = (state_r[i] == tmm_pkg::TMM_ST_COUNT);
      stat[i].irq_flag      = flag_r[i];
    end
    irq = irq_r;
  end

endmodule : tmm_timer

// >>> dv/tmm_timer_props.sv
// timer 0 checks for tmm_timer
// assumes a bind from the bench, one clock domain
`timescale 1ns/1ps
`include "tmm_defines.svh"
module tmm_timer_props (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire tmm_pkg::tmm_cfg_t  cfg [`TMM_NUM_TIMERS],
  input wire logic               tick_13m56,
  input wire logic               tick_212k,
  input wire logic               wakeup_underflow,
  input wire logic [3:0]         stop_event,
  input wire logic               ctrl_wr,
  input wire logic [3:0]         ctrl_running,
  input wire logic [3:0]         immediate_start_stop,
  input wire logic [3:0]         irq_clear,
  input wire logic [3:0]         irq_set,
  input wire tmm_pkg::tmm_stat_t stat [`TMM_NUM_TIMERS],
  input wire logic               irq
);
  logic [3:0]  src;
  logic [15:0] c;
  logic [15:0] rl;
  logic        r0;
  logic        tk;
  logic        h;
  logic        uf;
  assign src = {1'b0, wakeup_underflow, tick_212k, tick_13m56};
  assign tk = src[cfg[0].clk_sel];
  assign c = stat[0].counter_value;
  assign r0 = stat[0].running;
  assign rl = {cfg[0].reload_value_high, cfg[0].reload_value_low};
  // host writes and stop events outrank ticks, so only plain counting cycles qualify
  assign h = r0 && !(ctrl_wr && immediate_start_stop[0]) && !stop_event[0];
  assign uf = h && tk && c == 16'h0000;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_START: assert property (
    ctrl_wr && immediate_start_stop[0] && ctrl_running[0] && !r0 |=> r0 && c == $past(rl))
    else $error("start");
  AST_TICK: assert property (
    h && tk && c != 16'h0000 |=> r0 && c == $past(c) - 16'h0001) else $error("tick");
  AST_FROZEN: assert property (
    h && !tk |=> r0 && $stable(c)) else $error("frozen");
  AST_STOP: assert property (
    r0 && !ctrl_wr && stop_event[0] |=> !r0 && $stable(c)) else $error("stop");
  AST_ONCE: assert property (
    uf && !cfg[0].auto_reload_on_underflow |=> stat[0].irq_flag && !r0 && c == 16'h0000)
    else $error("once");
  AST_AUTO: assert property (
    uf && cfg[0].auto_reload_on_underflow |=> stat[0].irq_flag && r0 && c == $past(rl))
    else $error("auto");
  AST_PIN: assert property (
    stat[0].irq_flag && $past(cfg[0].irq_enable) |-> irq) else $error("pin");
  AST_CLR: assert property (
    irq_clear[0] && !irq_set[0] && !uf |=> !stat[0].irq_flag) else $error("clear");
endmodule : tmm_timer_props

// >>> dv/testbench.sv
// self-checking bench for tmm_timer, timer 0 exercised
// assumes tmm_pkg, tmm_timer and tmm_timer_props compiled first
`timescale 1ns/1ps
`include "tmm_defines.svh"
module testbench;
  logic               sys_clk = 0, rst = 1, ctrl_wr = 0;
  logic               tick_13m56 = 0, tick_212k = 0, wakeup_underflow = 0;
  logic [3:0]         stop_event = 0, ctrl_running = 0, immediate_start_stop = 0;
  logic [3:0]         irq_clear = 0, irq_set = 0;
  tmm_pkg::tmm_cfg_t  cfg [`TMM_NUM_TIMERS];
  tmm_pkg::tmm_stat_t stat [`TMM_NUM_TIMERS];
  logic               irq;
  logic [15:0]        q [$];
  logic [15:0]        r;
  int                 seed = 17346, err_total = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  tmm_timer dut_u (.sys_clk, .rst, .cfg, .tick_13m56, .tick_212k, .wakeup_underflow,
    .stop_event, .ctrl_wr, .ctrl_running, .immediate_start_stop, .irq_clear, .irq_set,
    .stat, .irq);
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic run);
    ctrl_wr <= 1'b1;
    ctrl_running <= {3'h0, run};
    immediate_start_stop <= 4'h1;
    @(posedge sys_clk);
    ctrl_wr <= 1'b0;
  endtask : wr
  // the second cycle of each pair pulses only the unselected sources, which must not count
  task automatic tk(int s, int n);
    repeat (n) begin
      {wakeup_underflow, tick_212k, tick_13m56} <= 3'h1 << s;
      @(posedge sys_clk);
      {wakeup_underflow, tick_212k, tick_13m56} <= ~(3'h1 << s);
      @(posedge sys_clk);
    end
    {wakeup_underflow, tick_212k, tick_13m56} <= 3'h0;
  endtask : tk
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  always @(negedge stat[0].running) begin
    #1;
    if (q.size() != 0) chk(stat[0].counter_value, q.pop_front());
  end
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
  initial begin
    for (int i = 0; i < `TMM_NUM_TIMERS; i++) cfg[i] = '{8'h00, 8'h00, tmm_pkg::TMM_CLK_NONE, 1'b0, 1'b0};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      // configure, start; s < 3 ticks then stops on an event, s == 3 runs through underflow and checks the pin
      r = (s == 3) ? (16'($random(seed)) & 16'h0007) : (16'h8000 | 16'($random(seed)));
      cfg[0] <= '{r[15:8], r[7:0], tmm_pkg::tmm_clk_sel_t'(s % 3), s == 3, 1'b1};
      wr(1'b1);
      if (s < 3) begin
        tk(s, s + 3);
        q.push_back(r - 16'(s + 3));
        stop_event <= 4'h1;
        @(posedge sys_clk);
        stop_event <= 4'h0;
        @(posedge sys_clk);
        chk(16'(q.size()), 16'h0000);
        continue;
      end
      tk(0, 2 * r + 2);
      chk({14'h0, stat[0].running, irq}, 16'h0003);
      q.push_back(r);
      wr(1'b0);
      irq_clear <= 4'h1;
      @(posedge sys_clk);
      irq_clear <= 4'h0;
      @(posedge sys_clk);
      chk({15'h0, irq}, 16'h0000);
    end
    // no-tick select freezes; host set shows flag, pin off while disabled
    cfg[0] <= '{8'h00, 8'h05, tmm_pkg::TMM_CLK_NONE, 1'b0, 1'b0};
    irq_set <= 4'h1;
    wr(1'b1);
    irq_set <= 4'h0;
    tk(0, 3);
    chk({13'h0, stat[0].running, stat[0].irq_flag, irq}, 16'h0006);
    q.push_back(16'h0005);
    wr(1'b0);
    @(posedge sys_clk);
    chk(16'(q.size()), 16'h0000);
    print_verdict();
  end
endmodule : testbench
bind tmm_timer tmm_timer_props chk_u (.sys_clk, .rst, .cfg, .tick_13m56, .tick_212k,
  .wakeup_underflow, .stop_event, .ctrl_wr, .ctrl_running, .immediate_start_stop,
  .irq_clear, .irq_set, .stat, .irq);
